/* inc/core_instruction_timing_consts.vh */
// Opcodes, special-function addresses, reset values and cycle counts of the core
`ifndef CORE_INSTRUCTION_TIMING_CONSTS_VH
`define CORE_INSTRUCTION_TIMING_CONSTS_VH
// ****************************************
// Special-function addresses
// ****************************************
`define ADDR_ACC 8'he0
`define ADDR_SECOND_OPERAND 8'hf0
`define ADDR_STATUS_WORD 8'hd0
`define ADDR_STACK_TOP 8'h81
`define ADDR_DATA_PTR_LO 8'h82
`define ADDR_DATA_PTR_HI 8'h83
`define ADDR_CTRL 8'hfe
`define ADDR_STATE 8'hff
// ****************************************
// Reset values and fields
// ****************************************
`define RST_SECOND_OPERAND 8'h00
`define RST_STACK_TOP 8'h07
`define CARRY_BIT 7
`define BANK_SELECT_LOW_BIT 3
`define BANK_SELECT_HIGH_BIT 4
`define BIT_AREA_BASE 4'h2
// ****************************************
// Opcodes
// ****************************************
`define OP_XOR_DIR_IMM 8'h63
`define OP_CLR_A 8'he4
`define OP_CPL_A 8'hf4
`define OP_RL_A 8'h23
`define OP_RLC_A 8'h33
`define OP_RR_A 8'h03
`define OP_RRC_A 8'h13
`define OP_SWAP_A 8'hc4
`define OP_MOV_A_RN 8'b11101???
`define OP_MOV_A_DIR 8'he5
`define OP_MOV_A_IND 8'b1110011?
`define OP_MOV_A_IMM 8'h74
`define OP_MOV_RN_A 8'b11111???
`define OP_MOV_RN_DIR 8'b10101???
`define OP_MOV_RN_IMM 8'b01111???
`define OP_MOV_DIR_A 8'hf5
`define OP_MOV_DIR_RN 8'b10001???
`define OP_MOV_DIR_DIR 8'h85
`define OP_MOV_DIR_IND 8'b1000011?
`define OP_MOV_DIR_IMM 8'h75
`define OP_MOV_IND_A 8'b1111011?
`define OP_MOV_IND_DIR 8'b1010011?
`define OP_MOV_IND_IMM 8'b0111011?
`define OP_LOAD_SIXTEEN_BIT_DATA_POINTER 8'h90
`define OP_CODE_READ_SIXTEEN_BIT_DATA_POINTER 8'h93
`define OP_CODE_READ_PC 8'h83
`define OP_EXT_RD_SIXTEEN_BIT_DATA_POINTER 8'he0
`define OP_EXT_RD_IND 8'b1110001?
`define OP_EXT_WR_SIXTEEN_BIT_DATA_POINTER 8'hf0
`define OP_EXT_WR_IND 8'b1111001?
`define OP_PUSH 8'hc0
`define OP_POP 8'hd0
`define OP_XCH_RN 8'b11001???
`define OP_XCH_DIR 8'hc5
`define OP_XCH_IND 8'b1100011?
`define OP_NIBBLE_SWAP 8'b1101011?
`define OP_CLR_C 8'hc3
`define OP_SETB_C 8'hd3
`define OP_CPL_C 8'hb3
`define OP_CLR_BIT 8'hc2
`define OP_SETB_BIT 8'hd2
`define OP_CPL_BIT 8'hb2
`define OP_MUL 8'ha4
// ****************************************
// Cycle counts
// ****************************************
`define MUL_CYCLES 4
`endif

/* hw/acc_unit.v */
// Accumulator-only operations: clear, complement, rotates, nibble swap
`timescale 1ns/1ps
`include "core_instruction_timing_consts.vh"
module acc_unit #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] acc_in,
  input wire cy_in,
  input wire [7:0] opcode,
  output reg [WIDTH-1:0] res,
  output reg cy_out
);
  localparam HALF = WIDTH / 2;
  always @* begin
    res = acc_in;
    cy_out = cy_in;
    case (opcode)
      `OP_CLR_A: res = {WIDTH{1'b0}};
      `OP_CPL_A: res = ~acc_in;
      `OP_RL_A: res = {acc_in[WIDTH-2:0], acc_in[WIDTH-1]};
      `OP_RR_A: res = {acc_in[0], acc_in[WIDTH-1:1]};
      `OP_RLC_A: begin
        res = {acc_in[WIDTH-2:0], cy_in};
        cy_out = acc_in[WIDTH-1];
      end
      `OP_RRC_A: begin
        res = {cy_in, acc_in[WIDTH-1:1]};
        cy_out = acc_in[0];
      end
      `OP_SWAP_A: res = {acc_in[HALF-1:0], acc_in[WIDTH-1:HALF]};
      default: res = acc_in;
    endcase
  end
endmodule

/* hw/core_instruction_timing.v */
// Instruction sequencer and datapath for transfer, logical and boolean groups
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "core_instruction_timing_consts.vh"
module core_instruction_timing #(
  parameter MUL_CYCLES = `MUL_CYCLES
) (
  input wire clk_sys,
  input wire srst,
  output reg [15:0] code_addr_q,
  input wire [7:0] code_data,
  output reg [15:0] xdata_addr_q,
  output reg [7:0] xdata_wdata_q,
  output reg xdata_we_q,
  output reg xdata_re_q,
  input wire [7:0] xdata_rdata,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [7:0] reg_rdata_q,
  output reg instr_done_q
);
  // ****************************************
  // State
  // ****************************************
  reg [7:0] iram [0:255];
  reg [7:0] acc_q;
  reg [7:0] second_operand_register_q;
  reg [7:0] program_status_word_q;
  reg [7:0] stack_top_pointer_q;
  reg [15:0] sixteen_bit_data_pointer_q;
  reg [15:0] program_counter_q;
  reg [7:0] opcode_q;
  reg [7:0] op1_q;
  reg [7:0] op2_q;
  reg [2:0] cyc_q;
  reg [7:0] tmp_q;
  reg run_q;
  // ****************************************
  // Decode
  // ****************************************
  wire [7:0] op = (cyc_q == 3'd0) ? code_data : opcode_q;
  wire [7:0] b1 = (cyc_q == 3'd1) ? code_data : op1_q;
  wire [7:0] b2 = (cyc_q == 3'd2) ? code_data : op2_q;
  reg [2:0] n_bytes;
  reg [2:0] n_cycles;
  always @* begin
    n_bytes = 3'd1;
    n_cycles = 3'd1;
    casez (op)
      `OP_XOR_DIR_IMM: begin
        n_bytes = 3'd3;
        n_cycles = 3'd3;
      end
      `OP_MOV_DIR_DIR: begin
        n_bytes = 3'd3;
        n_cycles = 3'd3;
      end
      `OP_MOV_DIR_IMM: begin
        n_bytes = 3'd3;
        n_cycles = 3'd3;
      end
      `OP_LOAD_SIXTEEN_BIT_DATA_POINTER: begin
        n_bytes = 3'd3;
        n_cycles = 3'd3;
      end
      `OP_CODE_READ_SIXTEEN_BIT_DATA_POINTER, `OP_CODE_READ_PC: n_cycles = 3'd3;
      `OP_EXT_RD_SIXTEEN_BIT_DATA_POINTER, `OP_EXT_RD_IND, `OP_EXT_WR_SIXTEEN_BIT_DATA_POINTER, `OP_EXT_WR_IND: n_cycles = 3'd3;
      `OP_MOV_A_IND, `OP_MOV_IND_A, `OP_XCH_IND: n_cycles = 3'd2;
      `OP_NIBBLE_SWAP: n_cycles = 3'd2;
      `OP_MOV_A_DIR, `OP_MOV_DIR_A, `OP_XCH_DIR, `OP_MOV_A_IMM, `OP_MOV_RN_DIR, `OP_MOV_RN_IMM,
      `OP_MOV_DIR_RN: begin
        n_bytes = 3'd2;
        n_cycles = 3'd2;
      end
      `OP_MOV_DIR_IND, `OP_MOV_IND_DIR: begin
        n_bytes = 3'd2;
        n_cycles = 3'd2;
      end
      `OP_MOV_IND_IMM: begin
        n_bytes = 3'd2;
        n_cycles = 3'd2;
      end
      `OP_PUSH, `OP_POP: begin
        n_bytes = 3'd2;
        n_cycles = 3'd2;
      end
      `OP_CLR_BIT, `OP_SETB_BIT, `OP_CPL_BIT: begin
        n_bytes = 3'd2;
        n_cycles = 3'd2;
      end
      `OP_MUL: n_cycles = MUL_CYCLES[2:0];
      default: n_cycles = 3'd1;
    endcase
  end
  // Idle only between instructions, so a halt never splits one
  wire active = run_q | (cyc_q != 3'd0);
  wire last = active && (cyc_q == n_cycles - 3'd1);
  wire consume = active && (cyc_q < n_bytes);
  wire is_code_read = (op == `OP_CODE_READ_SIXTEEN_BIT_DATA_POINTER) || (op == `OP_CODE_READ_PC);
  wire is_ext = (op[7:5] == 3'b111) && (op[3:2] == 2'b00) && (op[1:0] != 2'b01);
  wire is_bit_op = (op == `OP_CLR_BIT) || (op == `OP_SETB_BIT) || (op == `OP_CPL_BIT);
  // ****************************************
  // Operand fetch
  // ****************************************
  wire [1:0] bank = {program_status_word_q[`BANK_SELECT_HIGH_BIT],
    program_status_word_q[`BANK_SELECT_LOW_BIT]};
  wire [7:0] working_register_addr = {3'b000, bank, op[2:0]};
  wire [7:0] index_register_addr = {3'b000, bank, 2'b00, op[0]};
  wire [7:0] rn_rd = iram[working_register_addr];
  wire [7:0] index_register = iram[index_register_addr];
  wire [7:0] ind_rd = iram[index_register];
  wire [7:0] stack_rd = iram[stack_top_pointer_q];
  wire cy = program_status_word_q[`CARRY_BIT];
  wire [7:0] bit_byte_addr = b1[7] ? {b1[7:3], 3'b000} : {`BIT_AREA_BASE, b1[6:3]};
  wire [7:0] bit_mask = 8'h01 << b1[2:0];
  wire [7:0] dir_raddr = is_bit_op ? bit_byte_addr : b1;
  wire [15:0] pc_nx = consume ? program_counter_q + 16'h0001 : program_counter_q;
  wire [15:0] code_read_addr = {8'h00, acc_q} + (op[4] ? sixteen_bit_data_pointer_q : pc_nx);
  wire [15:0] product = acc_q * second_operand_register_q;
  function [7:0] space_rd;
    input [7:0] a;
    begin
      case (a)
        `ADDR_ACC: space_rd = acc_q;
        `ADDR_SECOND_OPERAND: space_rd = second_operand_register_q;
        `ADDR_STATUS_WORD: space_rd = program_status_word_q;
        `ADDR_STACK_TOP: space_rd = stack_top_pointer_q;
        `ADDR_DATA_PTR_LO: space_rd = sixteen_bit_data_pointer_q[7:0];
        `ADDR_DATA_PTR_HI: space_rd = sixteen_bit_data_pointer_q[15:8];
        default: space_rd = a[7] ? 8'h00 : iram[a];
      endcase
    end
  endfunction
  // Spelled out, as a function call would hide its sources from the update
  wire [7:0] dir_rd = (dir_raddr == `ADDR_ACC) ? acc_q :
    (dir_raddr == `ADDR_SECOND_OPERAND) ? second_operand_register_q :
    (dir_raddr == `ADDR_STATUS_WORD) ? program_status_word_q :
    (dir_raddr == `ADDR_STACK_TOP) ? stack_top_pointer_q :
    (dir_raddr == `ADDR_DATA_PTR_LO) ? sixteen_bit_data_pointer_q[7:0] :
    (dir_raddr == `ADDR_DATA_PTR_HI) ? sixteen_bit_data_pointer_q[15:8] :
    dir_raddr[7] ? 8'h00 : iram[dir_raddr];
  wire [7:0] alu_res;
  wire alu_cy;
  acc_unit #(
    .WIDTH(8)
  ) u_acc_unit (
    .acc_in(acc_q),
    .cy_in(cy),
    .opcode(op),
    .res(alu_res),
    .cy_out(alu_cy)
  );
  // ****************************************
  // Execute on the last cycle
  // ****************************************
  reg acc_we;
  reg [7:0] acc_nx;
  reg cy_we;
  reg cy_nx;
  reg sp_we;
  reg [7:0] sp_nx;
  reg sixteen_bit_data_pointer_we;
  reg b_we;
  reg wr_en;
  reg wr_ind;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  always @* begin
    acc_we = 1'b0;
    acc_nx = acc_q;
    cy_we = 1'b0;
    cy_nx = cy;
    sp_we = 1'b0;
    sp_nx = stack_top_pointer_q;
    sixteen_bit_data_pointer_we = 1'b0;
    b_we = 1'b0;
    wr_en = 1'b0;
    wr_ind = 1'b0;
    wr_addr = b1;
    wr_data = acc_q;
    if (last) begin
      casez (op)
        `OP_XOR_DIR_IMM: begin
          wr_en = 1'b1;
          wr_data = dir_rd ^ b2;
        end
        `OP_CLR_A, `OP_CPL_A, `OP_RL_A, `OP_RR_A, `OP_SWAP_A: begin
          acc_we = 1'b1;
          acc_nx = alu_res;
        end
        `OP_RLC_A, `OP_RRC_A: begin
          acc_we = 1'b1;
          acc_nx = alu_res;
          cy_we = 1'b1;
          cy_nx = alu_cy;
        end
        `OP_MOV_A_RN: begin
          acc_we = 1'b1;
          acc_nx = rn_rd;
        end
        `OP_MOV_A_DIR: begin
          acc_we = 1'b1;
          acc_nx = dir_rd;
        end
        `OP_MOV_A_IND: begin
          acc_we = 1'b1;
          acc_nx = ind_rd;
        end
        `OP_MOV_A_IMM: begin
          acc_we = 1'b1;
          acc_nx = b1;
        end
        `OP_MOV_RN_A: begin
          wr_en = 1'b1;
          wr_ind = 1'b1;
          wr_addr = working_register_addr;
        end
        `OP_MOV_RN_DIR, `OP_MOV_RN_IMM: begin
          wr_en = 1'b1;
          wr_ind = 1'b1;
          wr_addr = working_register_addr;
          wr_data = op[7] ? dir_rd : b1;
        end
        `OP_MOV_DIR_A: wr_en = 1'b1;
        `OP_MOV_DIR_RN: begin
          wr_en = 1'b1;
          wr_data = rn_rd;
        end
        `OP_MOV_DIR_DIR: begin
          wr_en = 1'b1;
          wr_addr = b2;
          wr_data = dir_rd;
        end
        `OP_MOV_DIR_IND: begin
          wr_en = 1'b1;
          wr_data = ind_rd;
        end
        `OP_MOV_DIR_IMM: begin
          wr_en = 1'b1;
          wr_data = b2;
        end
        `OP_MOV_IND_A, `OP_MOV_IND_DIR, `OP_MOV_IND_IMM: begin
          wr_en = 1'b1;
          wr_ind = 1'b1;
          wr_addr = index_register;
          wr_data = op[7] ? (op[6] ? acc_q : dir_rd) : b1;
        end
        `OP_LOAD_SIXTEEN_BIT_DATA_POINTER: sixteen_bit_data_pointer_we = 1'b1;
        `OP_CODE_READ_SIXTEEN_BIT_DATA_POINTER, `OP_CODE_READ_PC: begin
          acc_we = 1'b1;
          acc_nx = tmp_q;
        end
        `OP_EXT_RD_SIXTEEN_BIT_DATA_POINTER, `OP_EXT_RD_IND: begin
          acc_we = 1'b1;
          acc_nx = xdata_rdata;
        end
        `OP_PUSH: begin
          sp_we = 1'b1;
          sp_nx = stack_top_pointer_q + 8'h01;
          wr_en = 1'b1;
          wr_ind = 1'b1;
          wr_addr = stack_top_pointer_q + 8'h01;
          wr_data = dir_rd;
        end
        `OP_POP: begin
          sp_we = 1'b1;
          sp_nx = stack_top_pointer_q - 8'h01;
          wr_en = 1'b1;
          wr_data = stack_rd;
        end
        `OP_XCH_RN: begin
          acc_we = 1'b1;
          acc_nx = rn_rd;
          wr_en = 1'b1;
          wr_ind = 1'b1;
          wr_addr = working_register_addr;
        end
        `OP_XCH_DIR: begin
          acc_we = 1'b1;
          acc_nx = dir_rd;
          wr_en = 1'b1;
        end
        `OP_XCH_IND: begin
          acc_we = 1'b1;
          acc_nx = ind_rd;
          wr_en = 1'b1;
          wr_ind = 1'b1;
          wr_addr = index_register;
        end
        `OP_NIBBLE_SWAP: begin
          acc_we = 1'b1;
          acc_nx = {acc_q[7:4], ind_rd[3:0]};
          wr_en = 1'b1;
          wr_ind = 1'b1;
          wr_addr = index_register;
          wr_data = {ind_rd[7:4], acc_q[3:0]};
        end
        `OP_CLR_C, `OP_SETB_C, `OP_CPL_C: begin
          cy_we = 1'b1;
          cy_nx = op[6] ? op[4] : ~cy;
        end
        `OP_CLR_BIT, `OP_SETB_BIT, `OP_CPL_BIT: begin
          wr_en = 1'b1;
          wr_addr = bit_byte_addr;
          wr_data = op[6] ? (op[4] ? (dir_rd | bit_mask) : (dir_rd & ~bit_mask)) : (dir_rd ^ bit_mask);
        end
        `OP_MUL: begin
          acc_we = 1'b1;
          acc_nx = product[7:0];
          b_we = 1'b1;
          cy_we = 1'b1;
          cy_nx = 1'b0;
        end
        default: acc_we = 1'b0;
      endcase
    end
  end
  wire sfr_wr = wr_en && !wr_ind && wr_addr[7];
  // ****************************************
  // Sequencer and bus strobes
  // ****************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      cyc_q <= 3'd0;
      opcode_q <= 8'h00;
      op1_q <= 8'h00;
      op2_q <= 8'h00;
      program_counter_q <= 16'h0000;
      code_addr_q <= 16'h0000;
      tmp_q <= 8'h00;
      xdata_addr_q <= 16'h0000;
      xdata_wdata_q <= 8'h00;
      xdata_we_q <= 1'b0;
      xdata_re_q <= 1'b0;
      instr_done_q <= 1'b0;
    end else begin
      instr_done_q <= last;
      if (active) begin
        cyc_q <= last ? 3'd0 : cyc_q + 3'd1;
      end
      if (consume) begin
        case (cyc_q)
          3'd0: opcode_q <= code_data;
          3'd1: op1_q <= code_data;
          default: op2_q <= code_data;
        endcase
      end
      program_counter_q <= pc_nx;
      // Borrowing the code port stretches the instruction to three cycles; the opcode is already held
      if (active && cyc_q == 3'd0 && is_code_read) begin
        code_addr_q <= code_read_addr;
      end else begin
        code_addr_q <= pc_nx;
      end
      if (active && cyc_q == 3'd1 && is_code_read) begin
        tmp_q <= code_data;
      end
      xdata_we_q <= 1'b0;
      xdata_re_q <= 1'b0;
      if (active && cyc_q == 3'd0 && is_ext) begin
        xdata_addr_q <= op[1] ? {8'h00, index_register} : sixteen_bit_data_pointer_q;
        xdata_wdata_q <= acc_q;
        xdata_we_q <= op[4];
        xdata_re_q <= ~op[4];
      end
    end
  end
  // ****************************************
  // Register space, core and software ports
  // ****************************************
  // Software writes land after the core's, so a clash goes to software
  always @(posedge clk_sys) begin
    if (srst) begin
      acc_q <= 8'h00;
      second_operand_register_q <= `RST_SECOND_OPERAND;
      program_status_word_q <= 8'h00;
      stack_top_pointer_q <= `RST_STACK_TOP;
      sixteen_bit_data_pointer_q <= 16'h0000;
      run_q <= 1'b0;
    end else begin
      if (acc_we) acc_q <= acc_nx;
      if (cy_we) program_status_word_q[`CARRY_BIT] <= cy_nx;
      if (sp_we) stack_top_pointer_q <= sp_nx;
      if (sixteen_bit_data_pointer_we) sixteen_bit_data_pointer_q <= {b1, b2};
      if (b_we) second_operand_register_q <= product[15:8];
      if (sfr_wr) begin
        case (wr_addr)
          `ADDR_ACC: acc_q <= wr_data;
          `ADDR_SECOND_OPERAND: second_operand_register_q <= wr_data;
          `ADDR_STATUS_WORD: program_status_word_q <= wr_data;
          `ADDR_STACK_TOP: stack_top_pointer_q <= wr_data;
          `ADDR_DATA_PTR_LO: sixteen_bit_data_pointer_q[7:0] <= wr_data;
          `ADDR_DATA_PTR_HI: sixteen_bit_data_pointer_q[15:8] <= wr_data;
          default: run_q <= run_q;
        endcase
      end
      if (reg_we) begin
        case (reg_addr)
          `ADDR_ACC: acc_q <= reg_wdata;
          `ADDR_SECOND_OPERAND: second_operand_register_q <= reg_wdata;
          `ADDR_STATUS_WORD: program_status_word_q <= reg_wdata;
          `ADDR_STACK_TOP: stack_top_pointer_q <= reg_wdata;
          `ADDR_DATA_PTR_LO: sixteen_bit_data_pointer_q[7:0] <= reg_wdata;
          `ADDR_DATA_PTR_HI: sixteen_bit_data_pointer_q[15:8] <= reg_wdata;
          `ADDR_CTRL: run_q <= reg_wdata[0];
          default: run_q <= run_q;
        endcase
      end
    end
  end
  // Internal RAM has no reset; contents are undefined after power-up
  always @(posedge clk_sys) begin
    if (wr_en && (wr_ind || !wr_addr[7])) begin
      iram[wr_addr] <= wr_data;
    end
    if (reg_we && !reg_addr[7]) begin
      iram[reg_addr] <= reg_wdata;
    end
  end
  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        `ADDR_CTRL: reg_rdata_q <= {7'h00, run_q};
        `ADDR_STATE: reg_rdata_q <= {5'h00, cyc_q};
        default: reg_rdata_q <= space_rd(reg_addr);
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end
endmodule

/* test/core_instruction_timing_chk.sv */
// Checker for instruction timing and register read port of the core
`timescale 1ns/1ps
`include "core_instruction_timing_consts.vh"
module core_instruction_timing_chk #(
  parameter MUL_CYCLES = 4
) (
  input wire clk_sys,
  input wire srst,
  input wire [15:0] code_addr_q,
  input wire [7:0] code_data,
  input wire [15:0] xdata_addr_q,
  input wire [7:0] xdata_wdata_q,
  input wire xdata_we_q,
  input wire xdata_re_q,
  input wire [7:0] xdata_rdata,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  input wire [7:0] reg_rdata_q,
  input wire instr_done_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ****************************************
  // Instruction spans
  // ****************************************
  // Done pulse shares its cycle with the next opcode fetch
  sequence s_start(op);
    instr_done_q && (code_data ==? op);
  endsequence
  sequence s_gap2;
    !instr_done_q ##1 instr_done_q;
  endsequence
  sequence s_gap3;
    !instr_done_q [*2] ##1 instr_done_q;
  endsequence
  sequence s_b_wr;
    reg_we && reg_addr == `ADDR_SECOND_OPERAND;
  endsequence
  sequence s_b_rd;
    reg_re && reg_addr == `ADDR_SECOND_OPERAND;
  endsequence
  a_xor_three: assert property (s_start(`OP_XOR_DIR_IMM) |=> s_gap3)
    else $error("xor span wrong");
  a_acc_single: assert property (instr_done_q && code_data inside {`OP_CLR_A, `OP_CPL_A, `OP_RL_A,
    `OP_RLC_A, `OP_RR_A, `OP_RRC_A, `OP_SWAP_A, `OP_CLR_C, `OP_SETB_C, `OP_CPL_C} |=> instr_done_q)
    else $error("single cycle op too long");
  a_bank_single: assert property (instr_done_q && code_data inside {`OP_MOV_A_RN, `OP_MOV_RN_A,
    `OP_XCH_RN} |=> instr_done_q) else $error("bank move span wrong");
  a_ind_double: assert property (instr_done_q && code_data inside {`OP_MOV_A_IND, `OP_MOV_IND_A,
    `OP_XCH_IND, `OP_NIBBLE_SWAP, `OP_MOV_IND_DIR, `OP_MOV_DIR_IND, `OP_MOV_IND_IMM} |=> s_gap2)
    else $error("indirect span wrong");
  a_direct_pair: assert property (instr_done_q && code_data inside {`OP_MOV_A_DIR, `OP_MOV_DIR_A,
    `OP_CLR_BIT, `OP_SETB_BIT, `OP_CPL_BIT} |=> s_gap2) else $error("direct span wrong");
  a_direct_three: assert property (instr_done_q && code_data inside {`OP_MOV_DIR_DIR,
    `OP_MOV_DIR_IMM} |=> s_gap3) else $error("direct copy span wrong");
  a_pointer_load: assert property (s_start(`OP_LOAD_SIXTEEN_BIT_DATA_POINTER) |=> s_gap3)
    else $error("pointer load span wrong");
  a_code_read: assert property (instr_done_q && code_data inside {`OP_CODE_READ_SIXTEEN_BIT_DATA_POINTER,
    `OP_CODE_READ_PC} |=> s_gap3) else $error("code read span wrong");
  a_ext_span: assert property ((xdata_re_q || xdata_we_q) |=>
    !instr_done_q && !xdata_re_q && !xdata_we_q ##1 instr_done_q) else $error("external move span wrong");
  a_stack_pair: assert property (instr_done_q && code_data inside {`OP_PUSH, `OP_POP} |=> s_gap2)
    else $error("stack span wrong");
  a_second_rw: assert property (s_b_wr ##2 s_b_rd |=> reg_rdata_q == $past(reg_wdata, 3))
    else $error("second operand readback wrong");
  a_read_idle: assert property (!reg_re |=> reg_rdata_q == 8'h00)
    else $error("read data outside read slot");
endmodule
bind core_instruction_timing core_instruction_timing_chk #(.MUL_CYCLES(MUL_CYCLES)) chk_i (
  .clk_sys(clk_sys), .srst(srst), .code_addr_q(code_addr_q), .code_data(code_data),
  .xdata_addr_q(xdata_addr_q), .xdata_wdata_q(xdata_wdata_q), .xdata_we_q(xdata_we_q),
  .xdata_re_q(xdata_re_q), .xdata_rdata(xdata_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .instr_done_q(instr_done_q));

/* test/testbench.sv */
// Self-checking bench running a short program through the core
`timescale 1ns/1ps
`include "core_instruction_timing_consts.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  localparam MULC = 4;
  reg clk_sys = 0;
  reg srst = 1;
  reg [7:0] reg_addr = 0, reg_wdata = 0, xdata_rdata = 0;
  reg reg_we = 0, reg_re = 0;
  wire [15:0] code_addr_q, xdata_addr_q;
  wire [7:0] xdata_wdata_q, reg_rdata_q;
  wire xdata_we_q, xdata_re_q, instr_done_q;
  reg [7:0] code_mem [0:1023];
  // Past the table the fetch sees a harmless one-cycle filler
  wire [7:0] code_data = (code_addr_q < 16'd1024) ? code_mem[code_addr_q[9:0]] : 8'ha5;
  reg [7:0] one_cyc [0:9] = '{`OP_CLR_A, `OP_CPL_A, `OP_RL_A, `OP_RLC_A, `OP_RR_A, `OP_RRC_A,
    `OP_SWAP_A, `OP_CLR_C, `OP_SETB_C, `OP_CPL_C};
  int q_cyc[$], q_pc[$];
  int pc, gap, i, c, a, n_errors, checked;
  reg [7:0] d1, d2, d3, d4, x, m, xw_d;
  reg [15:0] v, mc_a, xw_a, xr_a, prod;
  core_instruction_timing #(.MUL_CYCLES(MULC)) core_instruction_timing_i (
    .clk_sys(clk_sys), .srst(srst), .code_addr_q(code_addr_q), .code_data(code_data),
    .xdata_addr_q(xdata_addr_q), .xdata_wdata_q(xdata_wdata_q), .xdata_we_q(xdata_we_q),
    .xdata_re_q(xdata_re_q), .xdata_rdata(xdata_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q), .instr_done_q(instr_done_q));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Far side of the external data port
  // ****************************************
  always @(posedge clk_sys) begin
    xdata_rdata <= xdata_re_q ? d4 : ~xdata_rdata;
    if (xdata_we_q) begin
      xw_a = xdata_addr_q;
      xw_d = xdata_wdata_q;
    end
    if (xdata_re_q) xr_a = xdata_addr_q;
  end
  // Span between done pulses must match the model's cycle count
  always @(posedge clk_sys) begin
    if (!srst && instr_done_q && q_cyc.size() > 0) begin
      c = q_cyc.pop_front();
      a = q_pc.pop_front();
      if (c > 0) `CHK("cycles", c, gap)
      `CHK("next_pc", a[15:0], code_addr_q)
      gap = 1;
    end else gap = gap + 1;
  end
  task ins(input int n, input [7:0] b0, b1, b2, input int cyc); begin
    code_mem[pc] = b0;
    if (n > 1) code_mem[pc + 1] = b1;
    if (n > 2) code_mem[pc + 2] = b2;
    pc = pc + n;
    q_cyc.push_back(cyc);
    q_pc.push_back(pc);
  end endtask
  task wr(input [7:0] ad, input [7:0] d); begin
    reg_addr <= ad;
    reg_wdata <= d;
    reg_we <= 1;
    @(posedge clk_sys);
    reg_we <= 0;
    @(posedge clk_sys);
  end endtask
  task rdchk(input [7:0] ad, input [7:0] e); begin
    reg_addr <= ad;
    reg_re <= 1;
    @(posedge clk_sys);
    reg_re <= 0;
    #1 `CHK("reg_rdata_q", e, reg_rdata_q)
    @(posedge clk_sys);
  end endtask
  task give_verdict; begin
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  end endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(5653));
    {d1, d2, d3, d4} = $urandom;
    v = $urandom;
    for (i = 0; i < 1024; i++) code_mem[i] = 8'ha5;
    ins(1, 8'ha5, 0, 0, -1);
    for (i = 0; i < 10; i++) ins(1, one_cyc[i], 0, 0, 1);
    ins(3, `OP_MOV_DIR_DIR, `ADDR_STATUS_WORD, 8'h33, 3);
    ins(3, `OP_LOAD_SIXTEEN_BIT_DATA_POINTER, v[15:8], v[7:0], 3);
    ins(2, `OP_MOV_A_IMM, d1, 0, 2);
    ins(2, `OP_MOV_DIR_A, `ADDR_SECOND_OPERAND, 0, 2);
    ins(2, `OP_CPL_BIT, `ADDR_SECOND_OPERAND, 0, 2);
    ins(3, `OP_MOV_DIR_IMM, 8'h30, d3, 3);
    ins(3, `OP_XOR_DIR_IMM, 8'h30, d2, 3);
    ins(1, `OP_CPL_A, 0, 0, 1);
    ins(3, `OP_MOV_DIR_IMM, `ADDR_STATUS_WORD, 8'h08, 3);
    ins(1, 8'hf8, 0, 0, 1);
    ins(3, `OP_MOV_DIR_DIR, 8'h30, 8'h31, 3);
    ins(2, `OP_PUSH, 8'h31, 0, 2);
    ins(1, `OP_EXT_WR_SIXTEEN_BIT_DATA_POINTER, 0, 0, 3);
    ins(1, `OP_EXT_RD_SIXTEEN_BIT_DATA_POINTER, 0, 0, 3);
    ins(1, `OP_CODE_READ_PC, 0, 0, 3);
    mc_a = pc + d4;
    ins(2, 8'h79, 8'h30, 0, 2);
    ins(1, 8'hd7, 0, 0, 2);
    ins(2, `OP_SETB_BIT, 8'h00, 0, 2);
    ins(2, `OP_CLR_BIT, 8'h01, 0, 2);
    ins(2, `OP_POP, 8'h32, 0, 2);
    ins(2, 8'ha7, 8'h32, 0, 2);
    ins(1, 8'hc7, 0, 0, 2);
    ins(1, `OP_MUL, 0, 0, MULC);
    x = d3 ^ d2;
    m = code_mem[mc_a[9:0]];
    prod = x * (d1 ^ 8'h01);
    repeat (3) @(posedge clk_sys);
    srst <= 0;
    rdchk(`ADDR_SECOND_OPERAND, 8'h00);
    rdchk(`ADDR_STACK_TOP, 8'h07);
    wr(`ADDR_SECOND_OPERAND, d2);
    rdchk(`ADDR_SECOND_OPERAND, d2);
    rdchk(8'h90, 8'h00);
    wr(8'h20, 8'h02);
    wr(`ADDR_CTRL, 8'h01);
    for (i = 0; i < 300 && q_cyc.size() > 0; i++) @(posedge clk_sys);
    if (q_cyc.size() > 0) begin
      n_errors++;
      $display("[ERR] program exp done got stuck");
    end
    wr(`ADDR_CTRL, 8'h00);
    repeat (4) @(posedge clk_sys);
    `CHK("xdata_wr_addr", v, xw_a)
    `CHK("xdata_wr_data", ~d1, xw_d)
    `CHK("xdata_rd_addr", v, xr_a)
    rdchk(`ADDR_ACC, prod[7:0]);
    rdchk(`ADDR_SECOND_OPERAND, prod[15:8]);
    rdchk(8'h30, {m[7:4], x[3:0]});
    rdchk(8'h31, x);
    rdchk(8'h32, x);
    rdchk(8'h08, x);
    rdchk(8'h09, 8'h30);
    rdchk(8'h20, 8'h01);
    rdchk(8'h33, 8'h00);
    rdchk(`ADDR_STACK_TOP, 8'h07);
    rdchk(`ADDR_STATUS_WORD, 8'h08);
    rdchk(`ADDR_DATA_PTR_HI, v[15:8]);
    rdchk(`ADDR_DATA_PTR_LO, v[7:0]);
    give_verdict;
  end
endmodule
